// >>> core/asc_consts.vh
/*
 * constants of the axis sensor / stop configuration block:
 * register offsets, configuration field positions, reset values, timing.
 * assumes a 25 MHz system clock and a byte-addressed 32-bit register port.
 */
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define ASC_ADDR_W          8
`define ASC_REG_CFG         8'h00
`define ASC_REG_OPMODE      8'h04
`define ASC_REG_STATUS      8'h08

// --------------------------------------------------------------
// configuration register fields
// --------------------------------------------------------------
`define ASC_CFG_LIMIT_STOP  3
`define ASC_CFG_SLOW_ACTION 4
`define ASC_CFG_SLOW_LATCH  5
`define ASC_CFG_SLOW_POL    6
`define ASC_CFG_HOME_POL    7
`define ASC_CFG_FAULT_STOP  8
`define ASC_CFG_FAULT_POL   9
`define ASC_CFG_CLR_ABRUPT  10
`define ASC_CFG_CLR_HOMING  11
`define ASC_CFG_WIDTH_LSB   12
`define ASC_CFG_WIDTH_MSB   14
`define ASC_CFG_MASK        32'h00007ff8
`define ASC_CFG_RESET       32'h00000000

// --------------------------------------------------------------
// operation code register
// --------------------------------------------------------------
`define ASC_OP_W            7
`define ASC_OP_RESET        7'h00
`define ASC_OP_FEED_LIMIT   7'h20
`define ASC_OP_FEED_MASK    7'h77

// --------------------------------------------------------------
// status register fields
// --------------------------------------------------------------
`define ASC_ST_LIMIT_POS    0
`define ASC_ST_LIMIT_NEG    1
`define ASC_ST_SLOW         2
`define ASC_ST_HOME         3
`define ASC_ST_FAULT        4
`define ASC_ST_EMERG        5
`define ASC_ST_SLOW_LATCH   6
`define ASC_ST_CLEAR        7
`define ASC_ST_LIMIT_END    8
`define ASC_ST_STATE_LSB    12

// --------------------------------------------------------------
// clear pulse timing
// --------------------------------------------------------------
// sized so every cycle product stays exactly counter wide
`define ASC_CLK_MHZ         16'h0019
`define ASC_CLR_W0_US       16'h000c
`define ASC_CLR_W1_US       16'h0066
`define ASC_CLR_W2_US       16'h0199
`define ASC_CLR_W3_US       16'h0640
`define ASC_CLR_W0_CYC      (`ASC_CLK_MHZ * `ASC_CLR_W0_US)
`define ASC_CLR_W1_CYC      (`ASC_CLK_MHZ * `ASC_CLR_W1_US)
`define ASC_CLR_W2_CYC      (`ASC_CLK_MHZ * `ASC_CLR_W2_US)
`define ASC_CLR_W3_CYC      (`ASC_CLK_MHZ * `ASC_CLR_W3_US)
`define ASC_CLR_CNT_W       16

`endif

// >>> core/asc_clear_pulse.v
/*
 * timed pulse generator for the deviation clear output.
 * assumes trig is a one-cycle pulse on clk and width is at least 1.
 */
`timescale 1ns/1ns
`default_nettype none

`include "asc_consts.vh"

module asc_clear_pulse (
	input  wire                        clk,
	input  wire                        resetn,
	input  wire                        trig,
	input  wire [`ASC_CLR_CNT_W-1:0]   width,
	output reg                         pulse_r
);

	reg [`ASC_CLR_CNT_W-1:0] cnt_r;

	// --------------------------------------------------------------
	// counter
	// --------------------------------------------------------------
	// a new trigger reloads, so an overlapping event stretches the pulse
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r   <= {`ASC_CLR_CNT_W{1'b0}};
			pulse_r <= 1'b0;
		end else if (trig) begin
			cnt_r   <= width - {{(`ASC_CLR_CNT_W-1){1'b0}}, 1'b1};
			pulse_r <= 1'b1;
		end else if (cnt_r != {`ASC_CLR_CNT_W{1'b0}}) begin
			cnt_r   <= cnt_r - {{(`ASC_CLR_CNT_W-1){1'b0}}, 1'b1};
		end else begin
			pulse_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> core/asc_axis_stop.v
/*
 * per-axis sensor and stop configuration logic: sensor synchronisers,
 * polarity, slowdown latch, stop decisions and the deviation clear pulse.
 * assumes a profile generator drives START, MOVING, DIR and HOME_DONE on CLK
 * and obeys STOP_NOW, STOP_DECEL and SLOW_REQ; sensor pins are asynchronous.
 */
// Design decisions made here: the address map and the address-and-strobe port.
// Overview of operation
// - configuration bit 4 makes an active slowdown input only slow the axis (0) or slow and halt it (1).
// - with bit 5 set, a short slowdown input is latched and keeps acting after it goes away.
// - starting an axis operation while the slowdown input is inactive clears the slowdown latch.
// - with bit 5 clear, the slowdown latch is held cleared.
// - bit 6 sets the active level of the slowdown input, 0 low and 1 high.
// - bit 7 sets the active level of the home sensor, 0 low and 1 high.
// - bit 8 makes an active drive fault stop the axis at once (0) or decelerate it (1).
// - bit 9 sets the active level of the drive fault input, 0 low and 1 high.
// - with bit 10 set, an immediate stop by either limit, a drive fault or emergency emits a clear pulse.
// - a decelerating stop never emits the automatic clear pulse.
// - in feed-to-limit mode the limit is a normal end, yet an immediate stop there still pulses.
// - with bit 11 set, each completed homing emits a clear pulse.
// - bits 12 to 14 pick the clear pulse width: 12 us, 102 us, 409 us or 1.6 ms.
`timescale 1ns/1ns
`default_nettype none

`include "asc_consts.vh"

module asc_axis_stop #(
	parameter [`ASC_CLR_CNT_W-1:0] CLR_W2_CYC = `ASC_CLR_W2_CYC,
	parameter [`ASC_CLR_CNT_W-1:0] CLR_W3_CYC = `ASC_CLR_W3_CYC
) (
	input  wire                    CLK,
	input  wire                    RESETN,
	input  wire [`ASC_ADDR_W-1:0]  ADDR,
	input  wire [31:0]             WDATA,
	input  wire                    WR,
	input  wire                    RD,
	output reg  [31:0]             RDATA,
	input  wire                    LIMIT_POS_IN,
	input  wire                    LIMIT_NEG_IN,
	input  wire                    SLOWDOWN_IN,
	input  wire                    HOME_SENSOR_IN,
	input  wire                    DRIVE_FAULT_IN,
	input  wire                    EMERGENCY_IN,
	input  wire                    START,
	input  wire                    MOVING,
	input  wire                    DIR,
	input  wire                    HOME_DONE,
	output reg                     STOP_NOW,
	output reg                     STOP_DECEL,
	output reg                     SLOW_REQ,
	output reg                     HOME_ACTIVE,
	output reg                     LIMIT_END,
	output wire                    DEVIATION_CLEAR
);

	// --------------------------------------------------------------
	// stop tracker states
	// --------------------------------------------------------------
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_RUN   = 4'h2;
	localparam [3:0] ST_DECEL = 4'h4;
	localparam [3:0] ST_HALT  = 4'h8;

	// sensor vector order
	localparam SN_LP = 0;
	localparam SN_LN = 1;
	localparam SN_SD = 2;
	localparam SN_HM = 3;
	localparam SN_FT = 4;
	localparam SN_EM = 5;

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------
	function pol_apply;
		input raw;
		input pol;
		begin
			pol_apply = pol ? raw : ~raw;
		end
	endfunction

	function [`ASC_CLR_CNT_W-1:0] width_sel;
		input [2:0] code;
		input [`ASC_CLR_CNT_W-1:0] w2;
		input [`ASC_CLR_CNT_W-1:0] w3;
		begin
			case (code)
				3'h0:    width_sel = `ASC_CLR_W0_CYC;
				3'h1:    width_sel = `ASC_CLR_W1_CYC;
				3'h2:    width_sel = w2;
				default: width_sel = w3;
			endcase
		end
	endfunction

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	reg  [31:0]             cfg_r;
	reg  [`ASC_OP_W-1:0]    op_r;
	reg  [5:0]              s1_r;
	reg  [5:0]              s2_r;
	reg  [5:0]              s3_r;
	reg  [5:0]              raw_r;
	reg                     slow_latch_r;
	reg                     slow_latch_nxt;
	reg  [3:0]              state_r;
	reg  [3:0]              state_nxt;
	reg                     moving_q_r;
	reg                     stop_now_nxt;
	reg                     stop_decel_nxt;
	reg                     clr_trig_nxt;
	reg                     limit_end_nxt;
	reg  [31:0]             rd_nxt;
	wire                    lim_pos_act;
	wire                    lim_neg_act;
	wire                    slow_act;
	wire                    home_act;
	wire                    fault_act;
	wire                    emerg_act;
	wire                    slow_eff;
	wire                    lim_hit;
	wire                    feed_to_limit;
	wire                    moving_fell;
	wire                    imm_cause;
	wire                    dec_cause;
	wire [`ASC_CLR_CNT_W-1:0] clr_width;

	// --------------------------------------------------------------
	// register port
	// --------------------------------------------------------------
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cfg_r <= `ASC_CFG_RESET;
			op_r  <= `ASC_OP_RESET;
		end else if (WR) begin
			if (ADDR == `ASC_REG_CFG) begin
				cfg_r <= WDATA & `ASC_CFG_MASK;
			end
			if (ADDR == `ASC_REG_OPMODE) begin
				op_r <= WDATA[`ASC_OP_W-1:0];
			end
		end
	end

	// read data stand only in the cycle after the strobe
	always @* begin
		rd_nxt = 32'h00000000;
		if (RD) begin
			case (ADDR)
				`ASC_REG_CFG:    rd_nxt = cfg_r;
				`ASC_REG_OPMODE: rd_nxt = {25'h0, op_r};
				`ASC_REG_STATUS: begin
					rd_nxt[`ASC_ST_LIMIT_POS]  = lim_pos_act;
					rd_nxt[`ASC_ST_LIMIT_NEG]  = lim_neg_act;
					rd_nxt[`ASC_ST_SLOW]       = slow_act;
					rd_nxt[`ASC_ST_HOME]       = home_act;
					rd_nxt[`ASC_ST_FAULT]      = fault_act;
					rd_nxt[`ASC_ST_EMERG]      = emerg_act;
					rd_nxt[`ASC_ST_SLOW_LATCH] = slow_latch_r;
					rd_nxt[`ASC_ST_CLEAR]      = DEVIATION_CLEAR;
					rd_nxt[`ASC_ST_LIMIT_END]  = LIMIT_END;
					rd_nxt[`ASC_ST_STATE_LSB+3:`ASC_ST_STATE_LSB] = state_r;
				end
				default: rd_nxt = 32'h00000000;
			endcase
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 32'h00000000;
		end else begin
			RDATA <= rd_nxt;
		end
	end

	// --------------------------------------------------------------
	// sensor synchronisers
	// --------------------------------------------------------------
	// third stage filters: a level counts once stages two and three agree
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s1_r  <= 6'h00;
			s2_r  <= 6'h00;
			s3_r  <= 6'h00;
			raw_r <= 6'h00;
		end else begin
			s1_r <= {EMERGENCY_IN, DRIVE_FAULT_IN, HOME_SENSOR_IN,
				SLOWDOWN_IN, LIMIT_NEG_IN, LIMIT_POS_IN};
			s2_r <= s1_r;
			s3_r <= s2_r;
			raw_r <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & raw_r);
		end
	end

	// --------------------------------------------------------------
	// polarity
	// --------------------------------------------------------------
	// limits and emergency have fixed active-high sense here
	assign lim_pos_act = raw_r[SN_LP];
	assign lim_neg_act = raw_r[SN_LN];
	assign emerg_act   = raw_r[SN_EM];
	assign slow_act    = pol_apply(raw_r[SN_SD], cfg_r[`ASC_CFG_SLOW_POL]);
	assign home_act    = pol_apply(raw_r[SN_HM], cfg_r[`ASC_CFG_HOME_POL]);
	assign fault_act   = pol_apply(raw_r[SN_FT], cfg_r[`ASC_CFG_FAULT_POL]);

	// --------------------------------------------------------------
	// slowdown latch
	// --------------------------------------------------------------
	always @* begin
		slow_latch_nxt = slow_latch_r;
		if (!cfg_r[`ASC_CFG_SLOW_LATCH]) begin
			slow_latch_nxt = 1'b0;
		end else if (slow_act) begin
			slow_latch_nxt = 1'b1;
		end else if (START) begin
			slow_latch_nxt = 1'b0;
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			slow_latch_r <= 1'b0;
		end else begin
			slow_latch_r <= slow_latch_nxt;
		end
	end

	assign slow_eff = slow_act | slow_latch_r;

	// --------------------------------------------------------------
	// stop causes
	// --------------------------------------------------------------
	// only the limit in the direction of travel can stop the axis
	assign lim_hit       = DIR ? lim_pos_act : lim_neg_act;
	assign feed_to_limit = (op_r & `ASC_OP_FEED_MASK) == `ASC_OP_FEED_LIMIT;
	assign moving_fell   = moving_q_r & ~MOVING;

	assign imm_cause = emerg_act
		| (fault_act & ~cfg_r[`ASC_CFG_FAULT_STOP])
		| (lim_hit & ~cfg_r[`ASC_CFG_LIMIT_STOP]);
	assign dec_cause = (fault_act & cfg_r[`ASC_CFG_FAULT_STOP])
		| (lim_hit & cfg_r[`ASC_CFG_LIMIT_STOP])
		| (slow_eff & cfg_r[`ASC_CFG_SLOW_ACTION]);

	// --------------------------------------------------------------
	// stop tracker
	// --------------------------------------------------------------
	// an immediate cause overrides a deceleration already under way
	always @* begin
		state_nxt      = state_r;
		stop_now_nxt   = 1'b0;
		stop_decel_nxt = 1'b0;
		clr_trig_nxt   = 1'b0;
		limit_end_nxt  = LIMIT_END;
		if (START) begin
			limit_end_nxt = 1'b0;
		end
		case (state_r)
			ST_IDLE: begin
				if (START) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN, ST_DECEL: begin
				if (imm_cause) begin
					state_nxt    = ST_HALT;
					stop_now_nxt = 1'b1;
					// limit end in feed-to-limit mode still pulses
					clr_trig_nxt = cfg_r[`ASC_CFG_CLR_ABRUPT];
					limit_end_nxt = feed_to_limit & lim_hit;
				end else if (state_r == ST_RUN && dec_cause) begin
					// no clear pulse on a decelerating stop
					state_nxt      = ST_DECEL;
					stop_decel_nxt = 1'b1;
					limit_end_nxt  = feed_to_limit & lim_hit;
				end else if (moving_fell) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_HALT: begin
				if (!MOVING && !START) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (HOME_DONE && cfg_r[`ASC_CFG_CLR_HOMING]) begin
			clr_trig_nxt = 1'b1;
		end
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r     <= ST_IDLE;
			moving_q_r  <= 1'b0;
			STOP_NOW    <= 1'b0;
			STOP_DECEL  <= 1'b0;
			SLOW_REQ    <= 1'b0;
			HOME_ACTIVE <= 1'b0;
			LIMIT_END   <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			moving_q_r  <= MOVING;
			STOP_NOW    <= stop_now_nxt;
			STOP_DECEL  <= stop_decel_nxt;
			SLOW_REQ    <= slow_eff;
			HOME_ACTIVE <= home_act;
			LIMIT_END   <= limit_end_nxt;
		end
	end

	// --------------------------------------------------------------
	// deviation clear pulse
	// --------------------------------------------------------------
	// codes above 3 are undefined; they fall back to the longest width
	assign clr_width = width_sel(cfg_r[`ASC_CFG_WIDTH_MSB:`ASC_CFG_WIDTH_LSB],
		CLR_W2_CYC, CLR_W3_CYC);

	reg clr_trig_r;

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			clr_trig_r <= 1'b0;
		end else begin
			clr_trig_r <= clr_trig_nxt;
		end
	end

	asc_clear_pulse u_clear (
		.clk     (CLK),
		.resetn  (RESETN),
		.trig    (clr_trig_r),
		.width   (clr_width),
		.pulse_r (DEVIATION_CLEAR)
	);

endmodule

`default_nettype wire

// >>> testbench/asc_axis_stop_assertions.sv
/* checker for the axis stop block: clear pulse causes and width, polarity, stops.
   assumes it sees only the top ports; cfg is shadowed from writes at 0x00. */
`timescale 1ns/1ns
`default_nettype none
`include "asc_consts.vh"
module asc_axis_stop_chk #(
	parameter [`ASC_CLR_CNT_W-1:0] CLR_W2_CYC = 16'h0014,
	parameter [`ASC_CLR_CNT_W-1:0] CLR_W3_CYC = 16'h0028
) (
	input wire logic                   CLK,
	input wire logic                   RESETN,
	input wire logic [`ASC_ADDR_W-1:0] ADDR,
	input wire logic [31:0]            WDATA,
	input wire logic                   WR,
	input wire logic                   SLOWDOWN_IN,
	input wire logic                   HOME_SENSOR_IN,
	input wire logic                   START,
	input wire logic                   HOME_DONE,
	input wire logic                   STOP_NOW,
	input wire logic                   STOP_DECEL,
	input wire logic                   SLOW_REQ,
	input wire logic                   HOME_ACTIVE,
	input wire logic                   LIMIT_END,
	input wire logic                   DEVIATION_CLEAR
);
	logic [14:0] cfg_r;
	logic        stop_d_r;
	logic        home_d1_r;
	logic        home_d2_r;
	logic [15:0] hi_cnt_r;
	logic [15:0] w_exp;
	wire         reload = stop_d_r | home_d2_r;
	// ----
	// helper: count of high cycles since the last (re)load
	// ----
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cfg_r <= 15'h0000;
			stop_d_r <= 1'b0;
			home_d1_r <= 1'b0;
			home_d2_r <= 1'b0;
			hi_cnt_r <= 16'h0000;
		end else begin
			if (WR && ADDR == `ASC_REG_CFG)
				cfg_r <= WDATA[14:0];
			stop_d_r <= STOP_NOW & cfg_r[10];
			home_d1_r <= HOME_DONE & cfg_r[11];
			home_d2_r <= home_d1_r;
			hi_cnt_r <= reload ? 16'h0001 : (DEVIATION_CLEAR ? hi_cnt_r + 16'h0001 : 16'h0000);
		end
	end
	// 12 us and 102 us at 25 MHz; longer codes follow the shortened parameters
	always_comb begin
		case (cfg_r[14:12])
			3'h0: w_exp = 16'h012c;
			3'h1: w_exp = 16'h09f6;
			3'h2: w_exp = CLR_W2_CYC;
			default: w_exp = CLR_W3_CYC;
		endcase
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// ----
	// properties
	// ----
	sequence s_home_steady;
		($stable(HOME_SENSOR_IN) && $stable(cfg_r[7]))[*8];
	endsequence
	sequence s_slow_steady;
		($stable(SLOWDOWN_IN) && $stable(cfg_r[6]) && !cfg_r[5])[*8];
	endsequence
	property p_clr_on_stop; STOP_NOW && cfg_r[10] |=> DEVIATION_CLEAR; endproperty
	property p_clr_on_home; HOME_DONE && cfg_r[11] |-> ##2 DEVIATION_CLEAR; endproperty
	property p_clr_cause; $rose(DEVIATION_CLEAR) |-> reload; endproperty
	property p_clr_width; $fell(DEVIATION_CLEAR) |-> hi_cnt_r == w_exp; endproperty
	property p_home_pol; s_home_steady |-> HOME_ACTIVE == (HOME_SENSOR_IN == cfg_r[7]); endproperty
	property p_slow_pol; s_slow_steady |-> SLOW_REQ == (SLOWDOWN_IN == cfg_r[6]); endproperty
	property p_stop_excl; STOP_NOW |-> !STOP_DECEL ##1 !STOP_NOW; endproperty
	property p_limend_clr; START |=> !LIMIT_END; endproperty
	a_clr_on_stop: assert property (p_clr_on_stop)
		else $error("no clear pulse after immediate stop");
	a_clr_on_home: assert property (p_clr_on_home)
		else $error("no clear pulse after homing");
	a_clr_cause: assert property (p_clr_cause)
		else $error("clear pulse without cause");
	a_clr_width: assert property (p_clr_width)
		else $error("clear pulse width wrong");
	a_home_pol: assert property (p_home_pol)
		else $error("home active level wrong");
	a_slow_pol: assert property (p_slow_pol)
		else $error("slowdown level wrong");
	a_stop_excl: assert property (p_stop_excl)
		else $error("stop request doubled or repeated");
	a_limend_clr: assert property (p_limend_clr)
		else $error("limit end not cleared by start");
endmodule
bind asc_axis_stop asc_axis_stop_chk #(.CLR_W2_CYC(CLR_W2_CYC), .CLR_W3_CYC(CLR_W3_CYC))
	i_asc_axis_stop_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
	.SLOWDOWN_IN(SLOWDOWN_IN), .HOME_SENSOR_IN(HOME_SENSOR_IN), .START(START),
	.HOME_DONE(HOME_DONE), .STOP_NOW(STOP_NOW), .STOP_DECEL(STOP_DECEL), .SLOW_REQ(SLOW_REQ),
	.HOME_ACTIVE(HOME_ACTIVE), .LIMIT_END(LIMIT_END), .DEVIATION_CLEAR(DEVIATION_CLEAR));
`default_nettype wire

// >>> testbench/asc_drive_model.sv
/* motion side model: raises moving after start, drops it on stop requests.
   assumes start and the stop requests are one-cycle pulses on clk. */
`timescale 1ns/1ns
`default_nettype none
module asc_drive_model #(
	parameter int DEC_CYC = 6
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start,
	input  wire logic stop_now,
	input  wire logic stop_decel,
	output var  logic moving
);
	logic [3:0] dec_cnt_r;
	// a decelerating stop takes a few cycles, so the block sees motion linger
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			moving <= 1'b0;
			dec_cnt_r <= 4'h0;
		end else if (start) begin
			moving <= 1'b1;
		end else if (stop_now) begin
			moving <= 1'b0;
			dec_cnt_r <= 4'h0;
		end else if (stop_decel && moving) begin
			dec_cnt_r <= 4'(DEC_CYC);
		end else if (dec_cnt_r != 4'h0) begin
			dec_cnt_r <= dec_cnt_r - 4'h1;
			if (dec_cnt_r == 4'h1)
				moving <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/asc_axis_stop_tb_top.sv
/* self-checking bench of the axis stop block with a drive model.
   assumes a 25 MHz clock and shortened long clear widths. */
`timescale 1ns/1ns
`default_nettype none
`include "asc_consts.vh"
module asc_axis_stop_tb_top;
	localparam logic [15:0] W2 = 16'h0014;
	localparam logic [15:0] W3 = 16'h0028;
	typedef struct packed {
		logic [15:0] cfg;
		logic [6:0]  op;
		logic [3:0]  act;
		logic        dir;
		logic        now;
		logic        dec;
		logic        clr;
	} asc_row_t;
	// act: limit, slowdown, fault, emergency
	localparam asc_row_t ROWS [10] = '{
		'{16'h0400, 7'h00, 4'h8, 1'b1, 1'b1, 1'b0, 1'b1},
		'{16'h0408, 7'h00, 4'h8, 1'b1, 1'b0, 1'b1, 1'b0},
		'{16'h0400, 7'h00, 4'h8, 1'b0, 1'b1, 1'b0, 1'b1},
		'{16'h0600, 7'h00, 4'h2, 1'b1, 1'b1, 1'b0, 1'b1},
		'{16'h0500, 7'h00, 4'h2, 1'b1, 1'b0, 1'b1, 1'b0},
		'{16'h0400, 7'h00, 4'h1, 1'b1, 1'b1, 1'b0, 1'b1},
		'{16'h0450, 7'h00, 4'h4, 1'b1, 1'b0, 1'b1, 1'b0},
		'{16'h0040, 7'h00, 4'h4, 1'b1, 1'b0, 1'b0, 1'b0},
		'{16'h0400, 7'h28, 4'h8, 1'b1, 1'b1, 1'b0, 1'b1},
		'{16'h0000, 7'h00, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0}
	};
	localparam logic [31:0] WEXP [6] = '{32'h012c, 32'h09f6, {16'h0, W2}, {16'h0, W3},
		{16'h0, W3}, 32'h0};
	logic        CLK, RESETN, WR, RD, START, DIR, HOME_DONE, MOVING;
	logic        LIMIT_POS_IN, LIMIT_NEG_IN, SLOWDOWN_IN, HOME_SENSOR_IN;
	logic        DRIVE_FAULT_IN, EMERGENCY_IN;
	logic        STOP_NOW, STOP_DECEL, SLOW_REQ, HOME_ACTIVE, LIMIT_END, DEVIATION_CLEAR;
	logic [7:0]  ADDR;
	logic [31:0] WDATA, RDATA, n;
	logic [2:0]  seen;
	asc_row_t    r;
	int          n_fail, compares;
	asc_axis_stop #(.CLR_W2_CYC(W2), .CLR_W3_CYC(W3)) i_asc_axis_stop (.CLK(CLK),
		.RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.LIMIT_POS_IN(LIMIT_POS_IN), .LIMIT_NEG_IN(LIMIT_NEG_IN), .SLOWDOWN_IN(SLOWDOWN_IN),
		.HOME_SENSOR_IN(HOME_SENSOR_IN), .DRIVE_FAULT_IN(DRIVE_FAULT_IN),
		.EMERGENCY_IN(EMERGENCY_IN), .START(START), .MOVING(MOVING), .DIR(DIR),
		.HOME_DONE(HOME_DONE), .STOP_NOW(STOP_NOW), .STOP_DECEL(STOP_DECEL),
		.SLOW_REQ(SLOW_REQ), .HOME_ACTIVE(HOME_ACTIVE), .LIMIT_END(LIMIT_END),
		.DEVIATION_CLEAR(DEVIATION_CLEAR));
	asc_drive_model i_asc_drive_model (.clk(CLK), .resetn(RESETN), .start(START),
		.stop_now(STOP_NOW), .stop_decel(STOP_DECEL), .moving(MOVING));
	// ----
	// tasks
	// ----
	task automatic report_and_stop();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1;
		chk(nm, RDATA, e);
	endtask
	task automatic set_pins(input logic [15:0] c, input logic [3:0] a, input logic d);
		@(posedge CLK);
		DIR <= d;
		LIMIT_POS_IN <= a[3] & d;
		LIMIT_NEG_IN <= a[3] & ~d;
		SLOWDOWN_IN <= a[2] ? c[6] : ~c[6];
		DRIVE_FAULT_IN <= a[1] ? c[9] : ~c[9];
		EMERGENCY_IN <= a[0];
	endtask
	task automatic pulse_start();
		@(posedge CLK);
		START <= 1'b1;
		@(posedge CLK);
		START <= 1'b0;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while ((MOVING !== 1'b0 || DEVIATION_CLEAR !== 1'b0) && k < 3000) begin
			@(posedge CLK);
			#1;
			k++;
		end
		if (k >= 3000) begin
			n_fail++;
			$display("Error idle expected 0 seen 1");
			report_and_stop();
		end
	endtask
	// rt: cycle after the rise at which homing completes again, 0 for none
	task automatic measure(input int rt, output logic [31:0] m);
		int k;
		k = 0;
		m = 0;
		@(posedge CLK);
		HOME_DONE <= 1'b1;
		@(posedge CLK);
		HOME_DONE <= 1'b0;
		#1;
		while (DEVIATION_CLEAR !== 1'b1 && k < 10) begin
			@(posedge CLK);
			#1;
			k++;
		end
		while (DEVIATION_CLEAR === 1'b1 && m < 3000) begin
			@(posedge CLK);
			HOME_DONE <= (m + 1 == rt);
			#1;
			m++;
		end
		if (m >= 3000) begin
			n_fail++;
			$display("Error clr_pulse expected 0 seen 1");
			report_and_stop();
		end
	endtask
	task automatic slow_pulse(input logic [15:0] c);
		set_pins(c, 4'h4, 1'b1);
		repeat (8) @(posedge CLK);
		set_pins(c, 4'h0, 1'b1);
		repeat (10) @(posedge CLK);
		#1;
	endtask
	task automatic halt_axis(input logic [15:0] c);
		set_pins(c, 4'h1, 1'b1);
		wait_idle();
		set_pins(c, 4'h0, 1'b1);
		// let the filtered emergency fall before any new start
		repeat (6) @(posedge CLK);
	endtask
	// ----
	// stimulus
	// ----
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	initial begin
		{RESETN, WR, RD, START, HOME_DONE, LIMIT_POS_IN, LIMIT_NEG_IN, EMERGENCY_IN} = 8'h00;
		{DIR, SLOWDOWN_IN, HOME_SENSOR_IN, DRIVE_FAULT_IN} = 4'hf;
		ADDR = 8'h00;
		WDATA = 32'h0;
		n_fail = 0;
		compares = 0;
		repeat (12) @(posedge CLK);
		RESETN <= 1'b1;
		repeat (8) @(posedge CLK);
		rd_chk("status", `ASC_REG_STATUS, 32'h00001000);
		rd_chk("unmapped", 8'h0c, 32'h0);
		for (int i = 0; i < 10; i++) begin
			r = ROWS[i];
			set_pins(r.cfg, 4'h0, r.dir);
			wr(`ASC_REG_CFG, {16'h0, r.cfg});
			wr(`ASC_REG_OPMODE, {25'h0, r.op});
			pulse_start();
			repeat (4) @(posedge CLK);
			set_pins(r.cfg, r.act, r.dir);
			seen = 3'h0;
			repeat (40) begin
				@(posedge CLK);
				#1;
				seen = seen | {STOP_NOW, STOP_DECEL, DEVIATION_CLEAR};
			end
			chk("stops", {29'h0, seen}, {29'h0, r.now, r.dec, r.clr});
			chk("limit_end", {31'h0, LIMIT_END}, {31'h0, r.op[5]});
			set_pins(r.cfg, {3'h0, MOVING}, r.dir);
			wait_idle();
			set_pins(r.cfg, 4'h0, r.dir);
			$display("row %0d done", i);
		end
		for (int j = 0; j < 4; j++) begin
			wr(`ASC_REG_CFG, {24'h0, j[1], 7'h0});
			@(posedge CLK);
			HOME_SENSOR_IN <= j[0];
			repeat (8) @(posedge CLK);
			#1;
			chk("home_active", {31'h0, HOME_ACTIVE}, {31'h0, j[1] == j[0]});
		end
		$display("home polarity done");
		set_pins(16'h0060, 4'h0, 1'b1);
		wr(`ASC_REG_CFG, 32'h60);
		// stale pin levels under the new polarity must settle first
		repeat (6) @(posedge CLK);
		pulse_start();
		slow_pulse(16'h0060);
		chk("slow_latched", {31'h0, SLOW_REQ}, 32'h1);
		wr(`ASC_REG_CFG, 32'h40);
		repeat (8) @(posedge CLK);
		#1;
		chk("latch_off", {31'h0, SLOW_REQ}, 32'h0);
		wr(`ASC_REG_CFG, 32'h60);
		slow_pulse(16'h0060);
		halt_axis(16'h0060);
		pulse_start();
		repeat (6) @(posedge CLK);
		#1;
		chk("latch_start", {31'h0, SLOW_REQ}, 32'h0);
		halt_axis(16'h0060);
		$display("latch done");
		for (int c = 0; c < 6; c++) begin
			wr(`ASC_REG_CFG, {17'h0, c[2:0], c < 5, 11'h0});
			measure(0, n);
			chk("clr_width", n, WEXP[c]);
		end
		wr(`ASC_REG_CFG, 32'h2800);
		measure(10, n);
		chk("clr_retrig", n, 32'h0000000c + {16'h0, W2});
		$display("clear width done");
		wr(`ASC_REG_CFG, 32'hffffffff);
		rd_chk("cfg_mask", `ASC_REG_CFG, 32'h00007ff8);
		@(posedge CLK);
		RESETN <= 1'b0;
		repeat (3) @(posedge CLK);
		RESETN <= 1'b1;
		rd_chk("cfg_reset", `ASC_REG_CFG, 32'h0);
		$display("reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
